// >>> msq_pkg.sv
// Purpose: shared constants and types of the multispeed stage sequencer
// Assumes: 100 MHz ref_clk, 32-bit plain register port with byte addresses
// Notes:   frequencies in 0.01 Hz units, stage times in 0.1 s units
package msq_pkg;
	localparam int NSTAGE  = 8;
	localparam int FREQ_W  = 16;
	localparam int TIME_W  = 16;
	localparam int MULT_W  = 6;
	localparam int TICKS_W = TIME_W + MULT_W;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;

	// register byte offsets; table regions hold one word per stage
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_MULT   = 8'h04;
	localparam logic [7:0] OFS_CFG    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_FREQ   = 8'h20;
	localparam logic [7:0] OFS_ACT    = 8'h40;
	localparam logic [7:0] OFS_TIME   = 8'h60;

	// configuration register fields
	localparam int CFG_SRC_LSB    = 0;
	localparam int CFG_RSRC_LSB   = 4;
	localparam int CFG_COMMREV    = 6;
	localparam int CFG_RAMPTERM   = 7;

	// run modes of the automatic sequencer
	localparam logic [1:0] MODE_OFF  = 2'h0;
	localparam logic [1:0] MODE_ONCE = 2'h1;
	localparam logic [1:0] MODE_LOOP = 2'h2;
	localparam logic [1:0] MODE_HOLD = 2'h3;

	// run command sources
	localparam logic [1:0] RSRC_PANEL = 2'h0;
	localparam logic [1:0] RSRC_TERM  = 2'h1;
	localparam logic [1:0] RSRC_COMM  = 2'h2;

	// values after reset and legal limits
	localparam logic [1:0]        MODE_RST   = 2'h0;
	localparam logic [MULT_W-1:0] MULT_RST   = 6'h01;
	localparam logic [MULT_W-1:0] MULT_MAX   = 6'h3c;
	localparam logic [TIME_W-1:0] TIME_RST   = 16'h00c8;
	localparam logic [TIME_W-1:0] TIME_MAX   = 16'hea60;
	localparam logic [11:0]       ACT_RST    = 12'h011;
	localparam logic [FREQ_W-1:0] FREQ_RST   = 16'h0000;
	localparam logic [3:0]        SRC_PRESET = 4'h6;
	localparam logic [7:0]        CFG_RST    = 8'h00;

	// timer tick of 0.1 s
	localparam int TICK_NS       = 100000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_ZERO,
		ST_HOLD,
		ST_DONE,
		ST_PRESET
	} msq_state_type;
endpackage

// >>> msq_stage_timer.sv
// Purpose: stage duration timer counting 0.1 s ticks
// Assumes: load carries the already scaled duration in ticks, never zero
// Notes:   hold freezes both the prescaler and the tick count
`timescale 1ns/1ps
module msq_stage_timer import msq_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	input  wire logic               load,
	input  wire logic [TICKS_W-1:0] load_ticks,
	input  wire logic               hold,
	output logic                    expired_q
);
	localparam int PRE_W = $clog2(TICK_CYCLES_P + 1);

	logic [PRE_W-1:0]   pre_q, pre_d;
	logic [TICKS_W-1:0] count_q, count_d;
	logic               expired_d;

	// prescaler makes the tick, count runs down to zero once per stage
	always_comb begin
		pre_d     = pre_q;
		count_d   = count_q;
		expired_d = 1'b0;
		if (load) begin
			pre_d   = '0;
			count_d = load_ticks;
		end else if (!hold && count_q != '0) begin
			if (pre_q == PRE_W'(TICK_CYCLES_P - 1)) begin
				pre_d   = '0;
				count_d = count_q - TICKS_W'(1);
				expired_d = (count_q == TICKS_W'(1));
			end else begin
				pre_d = pre_q + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q     <= '0;
			count_q   <= '0;
			expired_q <= 1'b0;
		end else if (clk_en) begin
			pre_q     <= pre_d;
			count_q   <= count_d;
			expired_q <= expired_d;
		end
	end

	chk_timer_load_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && load |=> count_q == $past(load_ticks))
		else $error("stage timer did not load the scaled duration");

	chk_timer_expire_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		expired_q |-> count_q == '0)
		else $error("stage timer expired with ticks left");
endmodule

// >>> msq_sequencer.sv
// Purpose: eight-stage preset speed and automatic timed stage sequencer
// Assumes: terminal pins are asynchronous, pid_active and at_zero are on ref_clk
// Notes:   the ramp generator itself lives outside; this block picks setpoint and ramp
`timescale 1ns/1ps
module msq_sequencer import msq_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wr_data,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	output logic [DATA_W-1:0]      reg_rd_data_q,
	input  wire logic [2:0]        speed_sel,
	input  wire logic              forward_terminal,
	input  wire logic              reverse_terminal,
	input  wire logic [1:0]        ramp_sel_term,
	input  wire logic              run_cmd,
	input  wire logic              ext_stop,
	input  wire logic              seq_pause,
	input  wire logic              seq_inhibit,
	input  wire logic              pid_active,
	input  wire logic              at_zero,
	output logic [FREQ_W-1:0]      freq_set_q,
	output logic                   dir_rev_q,
	output logic [1:0]             ramp_sel_q,
	output logic                   ramp_decel_q,
	output logic                   stop_req_q,
	output logic                   stage_done_q,
	output logic                   cycle_done_q,
	output logic [2:0]             stage_q
);
	localparam int PIN_W = 11;

	logic [PIN_W-1:0]  pin_meta_q, pin_sync_q;
	logic [2:0]        s_speed;
	logic              s_fwd, s_rev, s_run, s_stop, s_pause, s_inhibit;
	logic [1:0]        s_ramp;

	logic [1:0]        stage_run_mode_q, stage_run_mode_d;
	logic [MULT_W-1:0] stage_time_multiplier_q, stage_time_multiplier_d;
	logic [7:0]        cfg_q, cfg_d;
	logic [FREQ_W-1:0] freq_q [NSTAGE];
	logic [FREQ_W-1:0] freq_d [NSTAGE];
	logic [11:0]       stage_action_code_q [NSTAGE];
	logic [11:0]       stage_action_code_d [NSTAGE];
	logic [TIME_W-1:0] stage_run_time_q [NSTAGE];
	logic [TIME_W-1:0] stage_run_time_d [NSTAGE];
	logic [DATA_W-1:0] rd_data_d;

	msq_state_type     state_q, state_d;
	logic [2:0]        stage_d, tgt_idx, nxt_idx, first_idx;
	logic              nxt_found, first_found, enter, tload;
	logic [FREQ_W-1:0] freq_set_d;
	logic              dir_rev_d, ramp_decel_d, stop_req_d, stage_done_d, cycle_done_d;
	logic [1:0]        ramp_sel_d;
	logic              auto_en, preset_ok, stop_cond, tmr_expired;
	logic [TICKS_W-1:0] load_ticks;
	logic [3:0]        wr_digit2, wr_digit1, wr_digit0;
	logic [2:0]        wr_idx;

	// terminal pins pass two flops; only the second stage is read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else if (clk_en) begin
			pin_meta_q <= {speed_sel, forward_terminal, reverse_terminal, ramp_sel_term,
				run_cmd, ext_stop, seq_pause, seq_inhibit};
			pin_sync_q <= pin_meta_q;
		end
	end
	assign {s_speed, s_fwd, s_rev, s_ramp, s_run, s_stop, s_pause, s_inhibit} = pin_sync_q;

	assign wr_idx    = reg_addr[4:2];
	assign wr_digit2 = reg_wr_data[11:8];
	assign wr_digit1 = reg_wr_data[7:4];
	assign wr_digit0 = reg_wr_data[3:0];

	// register writes; out-of-range multiplier, action code and time values are dropped so the old setting stays
	always_comb begin
		stage_run_mode_d        = stage_run_mode_q;
		stage_time_multiplier_d = stage_time_multiplier_q;
		cfg_d                   = cfg_q;
		freq_d                  = freq_q;
		stage_action_code_d     = stage_action_code_q;
		stage_run_time_d        = stage_run_time_q;
		if (reg_wr_en) begin
			case (reg_addr[7:5])
				3'h0: begin
					if (reg_addr[4:2] == OFS_MODE[4:2])
						stage_run_mode_d = reg_wr_data[1:0];
					if (reg_addr[4:2] == OFS_MULT[4:2] && reg_wr_data[31:MULT_W] == '0
						&& reg_wr_data[MULT_W-1:0] != '0
						&& reg_wr_data[MULT_W-1:0] <= MULT_MAX)
						stage_time_multiplier_d = reg_wr_data[MULT_W-1:0];
					if (reg_addr[4:2] == OFS_CFG[4:2])
						cfg_d = reg_wr_data[7:0];
				end
				OFS_FREQ[7:5]: freq_d[wr_idx] = reg_wr_data[FREQ_W-1:0];
				OFS_ACT[7:5]: begin
					if (reg_wr_data[31:12] == '0 && wr_digit2 <= 4'h1
						&& wr_digit1 >= 4'h1 && wr_digit1 <= 4'h4
						&& wr_digit0 >= 4'h1 && wr_digit0 <= 4'h4)
						stage_action_code_d[wr_idx] = reg_wr_data[11:0];
				end
				OFS_TIME[7:5]: begin
					if (reg_wr_data[31:TIME_W] == '0 && reg_wr_data[TIME_W-1:0] <= TIME_MAX)
						stage_run_time_d[wr_idx] = reg_wr_data[TIME_W-1:0];
				end
				default: ;
			endcase
		end
	end

	// read data stands in the cycle after the strobe; unmapped reads give zero
	always_comb begin
		rd_data_d = '0;
		if (reg_rd_en) begin
			case (reg_addr[7:5])
				3'h0: begin
					case (reg_addr[4:2])
						OFS_MODE[4:2]:   rd_data_d = {30'h0, stage_run_mode_q};
						OFS_MULT[4:2]:   rd_data_d = {26'h0, stage_time_multiplier_q};
						OFS_CFG[4:2]:    rd_data_d = {24'h0, cfg_q};
						OFS_STATUS[4:2]: rd_data_d = {22'h0, ramp_decel_q, ramp_sel_q,
							dir_rev_q, state_q, stage_q};
						default:         rd_data_d = '0;
					endcase
				end
				OFS_FREQ[7:5]: rd_data_d = {16'h0, freq_q[wr_idx]};
				OFS_ACT[7:5]:  rd_data_d = {20'h0, stage_action_code_q[wr_idx]};
				OFS_TIME[7:5]: rd_data_d = {16'h0, stage_run_time_q[wr_idx]};
				default:       rd_data_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_run_mode_q        <= MODE_RST;
			stage_time_multiplier_q <= MULT_RST;
			cfg_q                   <= CFG_RST;
			reg_rd_data_q           <= '0;
			for (int i = 0; i < NSTAGE; i++) begin
				freq_q[i]              <= FREQ_RST;
				stage_action_code_q[i] <= ACT_RST;
				stage_run_time_q[i]    <= TIME_RST;
			end
		end else if (clk_en) begin
			stage_run_mode_q        <= stage_run_mode_d;
			stage_time_multiplier_q <= stage_time_multiplier_d;
			cfg_q                   <= cfg_d;
			reg_rd_data_q           <= rd_data_d;
			freq_q                  <= freq_d;
			stage_action_code_q     <= stage_action_code_d;
			stage_run_time_q        <= stage_run_time_d;
		end
	end

	// lowest stage with a nonzero time, overall and after the current one
	always_comb begin
		nxt_found   = 1'b0;
		nxt_idx     = '0;
		first_found = 1'b0;
		first_idx   = '0;
		for (int k = NSTAGE - 1; k >= 0; k--) begin
			if (stage_run_time_q[k] != '0) begin
				first_found = 1'b1;
				first_idx   = 3'(k);
				if (3'(k) > stage_q) begin
					nxt_found = 1'b1;
					nxt_idx   = 3'(k);
				end
			end
		end
	end

	// feedback control has priority, inhibit terminal blocks as well
	assign auto_en   = stage_run_mode_q != MODE_OFF && !pid_active && !s_inhibit;
	assign preset_ok = cfg_q[CFG_SRC_LSB +: 4] == SRC_PRESET;
	assign stop_cond = !s_run || s_stop || !auto_en;
	assign load_ticks = {6'h0, stage_run_time_q[tgt_idx]}
		* {16'h0, stage_time_multiplier_q};

	// sequencer: picks the stage, then setpoint, direction and ramp for it
	always_comb begin
		state_d      = state_q;
		stage_d      = stage_q;
		freq_set_d   = freq_set_q;
		dir_rev_d    = dir_rev_q;
		ramp_sel_d   = ramp_sel_q;
		ramp_decel_d = ramp_decel_q;
		stop_req_d   = 1'b0;
		stage_done_d = 1'b0;
		cycle_done_d = 1'b0;
		enter        = 1'b0;
		tload        = 1'b0;
		tgt_idx      = stage_q;
		case (state_q)
			ST_IDLE: begin
				freq_set_d = '0;
				if (s_run && !s_stop && auto_en && first_found) begin
					state_d = ST_RUN;
					enter   = 1'b1;
					tload   = 1'b1;
					tgt_idx = first_idx;
				end else if (s_run && !s_stop && !auto_en && preset_ok) begin
					state_d = ST_PRESET;
					enter   = 1'b1;
					tgt_idx = s_speed;
				end
			end
			ST_RUN: begin
				if (stop_cond) begin
					state_d = ST_IDLE;
				end else if (tmr_expired) begin
					stage_done_d = 1'b1;
					if (nxt_found) begin
						enter   = 1'b1;
						tload   = 1'b1;
						tgt_idx = nxt_idx;
					end else begin
						cycle_done_d = 1'b1;
						if (stage_run_mode_q == MODE_HOLD) begin
							state_d = ST_HOLD;
						end else begin
							state_d      = ST_ZERO;
							freq_set_d   = '0;
							ramp_decel_d = 1'b1;
							ramp_sel_d   = 2'(stage_action_code_q[stage_q][3:0] - 4'h1);
						end
					end
				end
			end
			ST_ZERO: begin
				if (stop_cond) begin
					state_d = ST_IDLE;
				end else if (at_zero) begin
					if (stage_run_mode_q == MODE_ONCE) begin
						stop_req_d = 1'b1;
						state_d    = ST_DONE;
					end else if (first_found) begin
						state_d = ST_RUN;
						enter   = 1'b1;
						tload   = 1'b1;
						tgt_idx = first_idx;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_HOLD: begin
				if (stop_cond)
					state_d = ST_IDLE;
			end
			ST_DONE: begin
				// wait for run to drop so a held run level does not restart the cycle
				freq_set_d = '0;
				if (!s_run)
					state_d = ST_IDLE;
			end
			ST_PRESET: begin
				if (!s_run || s_stop || auto_en || !preset_ok) begin
					state_d = ST_IDLE;
				end else if (s_speed != stage_q) begin
					enter   = 1'b1;
					tgt_idx = s_speed;
				end else begin
					freq_set_d = freq_q[stage_q];
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (enter) begin
			stage_d    = tgt_idx;
			freq_set_d = freq_q[tgt_idx];
			dir_rev_d  = stage_action_code_q[tgt_idx][8];
			if (freq_q[tgt_idx] < freq_set_q) begin
				ramp_decel_d = 1'b1;
				ramp_sel_d   = 2'(stage_action_code_q[stage_q][3:0] - 4'h1);
			end else begin
				ramp_decel_d = 1'b0;
				ramp_sel_d   = 2'(stage_action_code_q[tgt_idx][7:4] - 4'h1);
			end
		end
		if (state_d == ST_PRESET) begin
			// terminal and comm run sources override the stored direction
			if (cfg_q[CFG_RSRC_LSB +: 2] == RSRC_TERM)
				dir_rev_d = s_rev && !s_fwd;
			else if (cfg_q[CFG_RSRC_LSB +: 2] == RSRC_COMM)
				dir_rev_d = cfg_q[CFG_COMMREV];
			if (cfg_q[CFG_RAMPTERM])
				ramp_sel_d = s_ramp;
		end
	end

	msq_stage_timer #(
		.TICK_CYCLES_P (TICK_CYCLES_P)
	) u_timer (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.clk_en     (clk_en),
		.load       (tload),
		.load_ticks (load_ticks),
		.hold       (s_pause),
		.expired_q  (tmr_expired)
	);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q      <= ST_IDLE;
			stage_q      <= '0;
			freq_set_q   <= '0;
			dir_rev_q    <= 1'b0;
			ramp_sel_q   <= '0;
			ramp_decel_q <= 1'b0;
			stop_req_q   <= 1'b0;
			stage_done_q <= 1'b0;
			cycle_done_q <= 1'b0;
		end else if (clk_en) begin
			state_q      <= state_d;
			stage_q      <= stage_d;
			freq_set_q   <= freq_set_d;
			dir_rev_q    <= dir_rev_d;
			ramp_sel_q   <= ramp_sel_d;
			ramp_decel_q <= ramp_decel_d;
			stop_req_q   <= stop_req_d;
			stage_done_q <= stage_done_d;
			cycle_done_q <= cycle_done_d;
		end
	end

	chk_mode_off_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && stage_run_mode_q == MODE_OFF |=> state_q != ST_RUN)
		else $error("sequencer ran with run mode off");
	chk_pid_blocks_seq: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && pid_active |=> !(state_q inside {ST_RUN, ST_ZERO, ST_HOLD}))
		else $error("sequencer ran while feedback control active");
	chk_mult_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
		stage_time_multiplier_q >= MULT_RST && stage_time_multiplier_q <= MULT_MAX)
		else $error("multiplier out of range");
	chk_action_code_ok: assert property (@(posedge ref_clk) disable iff (!reset_n)
		stage_action_code_q[stage_q][11:8] <= 4'h1
		&& stage_action_code_q[stage_q][7:4] inside {[4'h1:4'h4]}
		&& stage_action_code_q[stage_q][3:0] inside {[4'h1:4'h4]})
		else $error("illegal action code stored");
	chk_once_stop_req: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state_q == ST_ZERO && at_zero && !stop_cond
		&& stage_run_mode_q == MODE_ONCE |=> stop_req_q && state_q == ST_DONE)
		else $error("no stop request after cycle in mode 1");
	chk_loop_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && state_q == ST_ZERO && at_zero && !stop_cond && first_found
		&& stage_run_mode_q == MODE_LOOP |=> state_q == ST_RUN && stage_q == $past(first_idx))
		else $error("mode 2 did not restart at first stage");
	chk_hold_stable: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_q == ST_HOLD && $past(state_q) == ST_HOLD |-> $stable(freq_set_q))
		else $error("setpoint moved while holding last stage");
	chk_skip_zero_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_q == ST_RUN |-> stage_run_time_q[stage_q] != '0)
		else $error("stage with zero time was run");
	chk_decel_on_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && enter && freq_q[tgt_idx] < freq_set_q
		&& !(state_d == ST_PRESET && cfg_q[CFG_RAMPTERM])
		|=> ramp_decel_q && ramp_sel_q == 2'($past(stage_action_code_q[stage_q][3:0]) - 4'h1))
		else $error("wrong ramp on slower stage");
	chk_accel_on_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clk_en && enter && freq_q[tgt_idx] >= freq_set_q && state_d == ST_RUN
		|=> !ramp_decel_q && ramp_sel_q == 2'($past(stage_action_code_q[tgt_idx][7:4]) - 4'h1))
		else $error("wrong ramp on faster stage");
endmodule

// >>> msq_drive_model.sv
// Purpose: far side of the sequencer, a drive that spins down to standstill
// Assumes: at_zero is reported on ref_clk, no synchroniser needed
// Notes:   spin-down is a fixed count so the ramp-to-zero wait is exercised
`timescale 1ns/1ps
module msq_drive_model import msq_pkg::*; #(
	parameter int SPIN_P = 6
) (
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic [FREQ_W-1:0] freq_set,
	output logic                   at_zero
);
	logic [7:0] cnt_d;
	logic [7:0] cnt_q;

	// count cycles with a zero setpoint; a nonzero setpoint spins up again
	always_comb begin
		cnt_d = cnt_q;
		if (freq_set != '0)
			cnt_d = 8'h00;
		else if (cnt_q != 8'(SPIN_P))
			cnt_d = cnt_q + 8'h01;
	end

	// the counter register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_d;
	end

	// standstill only once the spin-down has run out, never early
	assign at_zero = (cnt_q == 8'(SPIN_P)) && (freq_set == '0);
endmodule

// >>> tb.sv
// Purpose: self-checking bench of the stage sequencer
// Assumes: short timer tick of 4 cycles, drive model on the far side
// Notes:   expectations come from the stage table held in the bench
`timescale 1ns/1ps
module tb import msq_pkg::*;;
	logic ref_clk = 0, reset_n = 0, wr = 0, rd = 0, run = 0, stp = 0, inh = 0, pid = 0, rev = 0;
	logic fwd = 0, pau = 0;
	logic [1:0] rtm = 0;
	logic [7:0] addr = 0;
	logic [31:0] wdat = 0;
	logic [2:0] sel = 0;
	logic [31:0] rdat;
	logic [15:0] fset;
	logic [1:0] rsel;
	logic [2:0] stg;
	logic dir, dec, sreq, sdone, cdone, az;
	int miscompares = 0, n_tests = 0, cyc = 0, n_stop = 0, n_cd = 0, n_sd = 0;
	logic [15:0] f [8];
	logic [11:0] a [8];
	logic [15:0] t [8];

	always #5 ref_clk = ~ref_clk;

	// cycle count and pulse counters
	always @(posedge ref_clk) begin
		cyc++;
		if (sreq === 1'b1) n_stop++;
		if (cdone === 1'b1) n_cd++;
		if (sdone === 1'b1) n_sd++;
	end

	msq_sequencer #(.TICK_CYCLES_P(4)) i_msq_sequencer (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(1'b1), .reg_addr(addr), .reg_wr_data(wdat), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_rd_data_q(rdat), .speed_sel(sel), .forward_terminal(fwd),
		.reverse_terminal(rev), .ramp_sel_term(rtm), .run_cmd(run), .ext_stop(stp),
		.seq_pause(pau), .seq_inhibit(inh), .pid_active(pid), .at_zero(az),
		.freq_set_q(fset), .dir_rev_q(dir), .ramp_sel_q(rsel), .ramp_decel_q(dec),
		.stop_req_q(sreq), .stage_done_q(sdone), .cycle_done_q(cdone), .stage_q(stg));

	msq_drive_model i_msq_drive_model (.ref_clk(ref_clk), .reset_n(reset_n),
		.freq_set(fset), .at_zero(az));

	task summarize;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task wr_reg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		wr <= 1;
		addr <= ad;
		wdat <= d;
		@(posedge ref_clk);
		wr <= 0;
	endtask

	// read data stands in the cycle after the strobe only
	task rd_chk(input logic [7:0] ad, input logic [31:0] e, input string m);
		@(posedge ref_clk);
		rd <= 1;
		addr <= ad;
		@(posedge ref_clk);
		rd <= 0;
		#1 chk(rdat, e, m);
	endtask

	// bounded wait for a stage (8 = any stage) with a given setpoint
	task wait_on(input int s, input logic [15:0] fr);
		int k;
		k = 0;
		while (!((s > 7 || stg === s[2:0]) && fset === fr) && k < 400) begin
			@(negedge ref_clk);
			k++;
		end
		chk(k < 400, 1, "stage not reached");
	endtask

	task t_regs;
		logic [11:0] bad [4];
		int i, d, m, l;
		bad = '{12'h015, 12'h211, 12'h101, 12'h110};
		rd_chk(OFS_MODE, MODE_RST, "mode reset");
		rd_chk(OFS_MULT, MULT_RST, "mult reset");
		for (i = 0; i < 8; i++) begin
			rd_chk(OFS_TIME + 8'(4 * i), TIME_RST, "time reset");
			rd_chk(OFS_ACT + 8'(4 * i), ACT_RST, "code reset");
		end
		wr_reg(OFS_MULT, 61);
		wr_reg(OFS_MULT, 0);
		rd_chk(OFS_MULT, 1, "mult refused");
		wr_reg(OFS_MULT, 60);
		rd_chk(OFS_MULT, 60, "mult max");
		wr_reg(OFS_TIME, 60001);
		rd_chk(OFS_TIME, TIME_RST, "time refused");
		wr_reg(OFS_TIME, 60000);
		rd_chk(OFS_TIME, 60000, "time max");
		for (d = 0; d < 2; d++) for (m = 1; m < 5; m++) for (l = 1; l < 5; l++) begin
			wr_reg(OFS_ACT, 32'(d * 256 + m * 16 + l));
			rd_chk(OFS_ACT, 32'(d * 256 + m * 16 + l), "code kept");
		end
		for (i = 0; i < 4; i++) begin
			wr_reg(OFS_ACT, 32'(bad[i]));
			rd_chk(OFS_ACT, 32'h144, "code refused");
		end
		rd_chk(8'hfc, 0, "unmapped read");
		$display("test registers done");
	endtask

	// stage table: stage 2 has zero time, stage 4 is slower than stage 3
	task cfg_stages;
		int i;
		for (i = 0; i < 8; i++) begin
			f[i] = 16'(100 * (i + 1));
			a[i] = (12'(i & 1) << 8) | (12'(i % 4 + 1) << 4) | 12'((i + 1) % 4 + 1);
			t[i] = (i == 2) ? 16'h0000 : ((i == 3) ? 16'h0003 : 16'h0001);
		end
		f[4] = 16'h0096;
		for (i = 0; i < 8; i++) begin
			wr_reg(OFS_FREQ + 8'(4 * i), 32'(f[i]));
			wr_reg(OFS_ACT + 8'(4 * i), 32'(a[i]));
			wr_reg(OFS_TIME + 8'(4 * i), 32'(t[i]));
		end
		wr_reg(OFS_MULT, 2);
	endtask

	task t_auto(input logic [1:0] m);
		logic [15:0] pf;
		logic [1:0] es;
		int i, pi, c3, n0, c0, sd0;
		wr_reg(OFS_MODE, 32'(m));
		run <= 1;
		pf = 0;
		pi = 0;
		n0 = n_stop;
		c0 = n_cd;
		sd0 = n_sd;
		for (i = 0; i < 8; i++) if (t[i] != 0) begin
			wait_on(i, f[i]);
			if (i == 3) c3 = cyc;
			if (i == 4) chk((cyc - c3 >= 24) && (cyc - c3 <= 25), 1, "stage time");
			es = (f[i] < pf) ? a[pi][1:0] - 2'd1 : a[i][5:4] - 2'd1;
			chk(dec, f[i] < pf, "decel flag");
			chk(rsel, es, "ramp select");
			chk(dir, a[i][8], "direction");
			pf = f[i];
			pi = i;
		end
		if (m == MODE_HOLD) begin
			repeat (40) @(negedge ref_clk);
			chk(fset, f[7], "hold freq");
			chk(n_cd - c0, 1, "cycle done");
			// seven stages have a nonzero time, each ends with one pulse
			chk(n_sd - sd0, 7, "stage done");
		end else begin
			wait_on(8, 0);
			chk(dec, 1, "zero decel");
			chk(rsel, a[7][1:0] - 2'd1, "zero ramp");
			if (m == MODE_ONCE) begin
				repeat (50) @(negedge ref_clk);
				chk(n_stop - n0, 1, "stop request");
			end else begin
				wait_on(0, f[0]);
				@(posedge ref_clk) stp <= 1;
				repeat (10) @(negedge ref_clk);
				chk(fset, 0, "external stop");
				@(posedge ref_clk) run <= 0;
				stp <= 0;
			end
		end
		@(posedge ref_clk) run <= 0;
		repeat (10) @(negedge ref_clk);
		$display("test auto mode %0d done", m);
	endtask

	task t_preset;
		int i;
		wr_reg(OFS_MODE, MODE_OFF);
		wr_reg(OFS_CFG, SRC_PRESET);
		run <= 1;
		for (i = 0; i < 8; i++) begin
			@(posedge ref_clk) sel <= 3'(i);
			repeat (6) @(negedge ref_clk);
			chk(fset, f[i], "preset freq");
			chk(dir, a[i][8], "preset dir");
		end
		wr_reg(OFS_CFG, 32'(SRC_PRESET) | 32'h10);
		rev <= 1;
		sel <= 0;
		repeat (6) @(negedge ref_clk);
		chk(dir, 1, "terminal dir");
		@(posedge ref_clk) fwd <= 1;
		repeat (6) @(negedge ref_clk);
		chk(dir, 0, "both terminals");
		// terminals still say reverse, so only the comm bit can give forward
		wr_reg(OFS_CFG, 32'h26);
		fwd <= 0;
		repeat (6) @(negedge ref_clk);
		chk(dir, 0, "comm forward");
		wr_reg(OFS_CFG, 32'h66);
		repeat (6) @(negedge ref_clk);
		chk(dir, 1, "comm dir");
		wr_reg(OFS_CFG, 32'h86);
		rtm <= 2'h2;
		repeat (6) @(negedge ref_clk);
		chk(rsel, 2, "terminal ramp");
		@(posedge ref_clk) run <= 0;
		rev <= 0;
		rtm <= 0;
		wr_reg(OFS_CFG, 0);
		repeat (10) @(negedge ref_clk);
		$display("test preset done");
	endtask

	task t_block;
		wr_reg(OFS_MODE, MODE_OFF);
		run <= 1;
		repeat (30) @(negedge ref_clk);
		chk(fset, 0, "mode off");
		@(posedge ref_clk) pid <= 1;
		wr_reg(OFS_MODE, MODE_HOLD);
		repeat (30) @(negedge ref_clk);
		chk(fset, 0, "feedback mode");
		@(posedge ref_clk) inh <= 1;
		repeat (5) @(posedge ref_clk);
		pid <= 0;
		repeat (30) @(negedge ref_clk);
		chk(fset, 0, "inhibit");
		@(posedge ref_clk) inh <= 0;
		wait_on(0, f[0]);
		// stage 0 would end after nine cycles; pause must freeze it
		@(posedge ref_clk) pau <= 1;
		repeat (30) @(negedge ref_clk);
		chk(stg, 0, "pause");
		@(posedge ref_clk) pau <= 0;
		wait_on(1, f[1]);
		@(posedge ref_clk) run <= 0;
		$display("test blocking done");
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1;
		t_regs;
		cfg_stages;
		t_auto(MODE_HOLD);
		t_auto(MODE_ONCE);
		t_auto(MODE_LOOP);
		t_preset;
		t_block;
		summarize;
	end

	// watchdog at ten thousand cycles, several times the expected run
	initial begin
		#100000;
		miscompares++;
		summarize;
	end
endmodule
